// >>> rtl/tpsc_top.sv
// Three-module power stage PWM controller: counters, waveform parts A and B, coherent update,
// overlap protection, fault and retrigger inputs, interrupt and ADC sync outputs.
// Assumes all inputs synchronous to sys_clk; the PLL clock arrives as a sampled input.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module tpsc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tpsc_pkg::tpsc_bus_t regBus,
  output logic [tpsc_pkg::DW-1:0] regRdata,
  input wire logic pllClkIn,
  input wire logic [tpsc_pkg::NUM_MOD-1:0] moduleFaultInput,
  output logic [tpsc_pkg::NUM_MOD-1:0] moduleOutputA,
  output logic [tpsc_pkg::NUM_MOD-1:0] moduleOutputB,
  output logic [tpsc_pkg::NUM_MOD-1:0] moduleIrqRequest,
  output logic [tpsc_pkg::NUM_MOD-1:0] adcSyncOut
);
  import tpsc_pkg::*;

  tpsc_state_t q;
  tpsc_state_t d;
  logic tick;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Prescaler, register port and per-module waveform engines
  always_comb begin
    logic srcTick;
    logic [1:0] divSel;
    logic run;
    logic center;
    logic lock;
    logic endEv;
    logic load;
    logic inAct;
    logic inWasAct;
    logic inEdge;
    logic faultMode;
    logic onA;
    logic onB;
    logic [CW-1:0] newRb;
    tpsc_chan_t c;
    srcTick = 1'b0;
    divSel = 2'b00;
    run = 1'b0;
    center = 1'b0;
    lock = 1'b0;
    endEv = 1'b0;
    load = 1'b0;
    inAct = 1'b0;
    inWasAct = 1'b0;
    inEdge = 1'b0;
    faultMode = 1'b0;
    onA = 1'b0;
    onB = 1'b0;
    newRb = '0;
    c = '0;
    d = q;
    d.rdata = 8'h00;

    // Counter clock: I/O clock or rising PLL edges, then divided
    srcTick = q.ctrl[CTRL_CLKSEL_BIT] ? (pllClkIn && !q.pllPrev) : 1'b1;
    divSel = q.ctrl[CTRL_DIV_LSB +: 2];
    tick = srcTick && ((q.presc & DIV_MASK[divSel]) == DIV_MASK[divSel]);
    d.pllPrev = pllClkIn;
    if (srcTick) begin
      d.presc = q.presc + PRESC_STEP;
    end

    // Register writes
    if (regBus.wr) begin
      case (regBus.addr)
        REG_CTRL: d.ctrl = regBus.wdata;
        REG_OUTCFG: d.outCfg = regBus.wdata;
        REG_OUTMODE2: d.outMode2 = regBus.wdata;
        REG_TEMPHI: d.temp = regBus.wdata;
        REG_B_RESET: d.pendRb = {q.temp[3:0], regBus.wdata};
        REG_B_RESET + 6'h01: d.temp = regBus.wdata;
        default: begin
        end
      endcase
      for (int n = 0; n < NUM_MOD; n++) begin
        if (regBus.addr == REG_INCTRL_BASE + AW'(n)) begin
          d.inCtrl[n] = regBus.wdata;
        end
        if (regBus.addr == REG_STATUS) begin
          if (regBus.wdata[n]) d.chan[n].endFlag = 1'b0;
          if (regBus.wdata[STAT_FAULT_LSB + n]) d.chan[n].faultFlag = 1'b0;
        end
        if (regBus.addr == cmpAddr(n, OFF_A_SET)) begin
          d.chan[n].pend.partASetCompare = {q.temp[3:0], regBus.wdata};
        end
        if (regBus.addr == cmpAddr(n, OFF_A_RESET)) begin
          d.chan[n].pend.partAResetCompare = {q.temp[3:0], regBus.wdata};
        end
        if (regBus.addr == cmpAddr(n, OFF_B_SET)) begin
          d.chan[n].pend.partBSetCompare = {q.temp[3:0], regBus.wdata};
        end
        // High bytes of every compare register land in the shared temp byte
        if (regBus.addr == cmpAddr(n, OFF_A_SET) + 6'h01 || regBus.addr == cmpAddr(n, OFF_A_RESET) + 6'h01
            || regBus.addr == cmpAddr(n, OFF_B_SET) + 6'h01) begin
          d.temp = regBus.wdata;
        end
      end
    end

    // Register reads, answered in the next cycle only
    if (regBus.rd) begin
      case (regBus.addr)
        REG_CTRL: d.rdata = q.ctrl;
        REG_OUTCFG: d.rdata = q.outCfg;
        REG_OUTMODE2: d.rdata = q.outMode2;
        REG_TEMPHI: d.rdata = q.temp;
        REG_B_RESET: d.rdata = q.pendRb[7:0];
        REG_B_RESET + 6'h01: d.rdata = {4'h0, q.pendRb[CW-1:8]};
        default: d.rdata = 8'h00;
      endcase
      for (int n = 0; n < NUM_MOD; n++) begin
        if (regBus.addr == REG_STATUS) begin
          d.rdata[n] = q.chan[n].endFlag;
          d.rdata[STAT_FAULT_LSB + n] = q.chan[n].faultFlag;
        end
        if (regBus.addr == REG_INCTRL_BASE + AW'(n)) d.rdata = q.inCtrl[n];
        if (regBus.addr == cmpAddr(n, OFF_A_SET)) d.rdata = q.chan[n].pend.partASetCompare[7:0];
        if (regBus.addr == cmpAddr(n, OFF_A_SET) + 6'h01) d.rdata = {4'h0, q.chan[n].pend.partASetCompare[CW-1:8]};
        if (regBus.addr == cmpAddr(n, OFF_A_RESET)) d.rdata = q.chan[n].pend.partAResetCompare[7:0];
        if (regBus.addr == cmpAddr(n, OFF_A_RESET) + 6'h01) begin
          d.rdata = {4'h0, q.chan[n].pend.partAResetCompare[CW-1:8]};
        end
        if (regBus.addr == cmpAddr(n, OFF_B_SET)) d.rdata = q.chan[n].pend.partBSetCompare[7:0];
        if (regBus.addr == cmpAddr(n, OFF_B_SET) + 6'h01) d.rdata = {4'h0, q.chan[n].pend.partBSetCompare[CW-1:8]};
      end
    end

    // Waveform engines, one per module
    center = q.ctrl[CTRL_CENTER_BIT];
    lock = q.ctrl[CTRL_LOCK_BIT];
    for (int n = 0; n < NUM_MOD; n++) begin
      c = q.chan[n];
      run = q.ctrl[CTRL_RUN_LSB + n];
      faultMode = q.inCtrl[n][IN_FAULT_BIT];

      // Cycle end on the part B reset match, in the up phase when centered
      endEv = run && tick && (c.cnt == c.act.partBResetCompare)
              && (!center || c.phase == PH_UP);

      // Input edge toward its programmed active level
      inAct = moduleFaultInput[n] == q.inCtrl[n][IN_LEVEL_BIT];
      inWasAct = c.inPrev == q.inCtrl[n][IN_LEVEL_BIT];
      inEdge = q.inCtrl[n][IN_EN_BIT] && inAct && !inWasAct;
      d.chan[n].inPrev = moduleFaultInput[n];

      // Coherent transfer of the pending set, held off by the lock bit
      load = !lock && (endEv || !run);
      newRb = load ? q.pendRb : c.act.partBResetCompare;
      if (load) begin
        d.chan[n].act = c.pend;
        d.chan[n].act.partBResetCompare = q.pendRb;
        d.chan[n].actEn = q.outCfg[2*n +: 2];
        d.chan[n].actPol = q.outMode2[2*n +: 2];
      end

      // Counter: parked while stopped, restarted by retrigger, else advanced
      if (!run) begin
        d.chan[n].cnt = center ? newRb : '0;
        d.chan[n].phase = center ? PH_DOWN : PH_UP;
      end else if (inEdge && !faultMode) begin
        d.chan[n].cnt = center ? c.act.partBResetCompare : '0;
        d.chan[n].phase = center ? PH_DOWN : PH_UP;
      end else if (tick) begin
        if (!center) begin
          d.chan[n].phase = PH_UP;
          d.chan[n].cnt = endEv ? '0 : c.cnt + 12'h001;
        end else begin
          case (c.phase)
            PH_UP: begin
              if (endEv) begin
                d.chan[n].phase = PH_DOWN;
                d.chan[n].cnt = newRb;
              end else begin
                d.chan[n].cnt = c.cnt + 12'h001;
              end
            end
            PH_DOWN: begin
              if (c.cnt == '0) begin
                d.chan[n].phase = PH_UP;
              end else begin
                d.chan[n].cnt = c.cnt - 12'h001;
              end
            end
            default: begin
              d.chan[n].phase = PH_DOWN;
              d.chan[n].cnt = newRb;
            end
          endcase
        end
      end

      // Fault halts the module until software sets its run bit again
      if (run && inEdge && faultMode) begin
        d.ctrl[CTRL_RUN_LSB + n] = 1'b0;
      end

      // Output waveform from the compare values
      if (center) begin
        onA = c.cnt < c.act.partASetCompare;
        onB = c.cnt >= c.act.partBSetCompare;
      end else begin
        onA = (c.cnt > c.act.partASetCompare) && (c.cnt <= c.act.partAResetCompare);
        onB = (c.cnt > c.act.partBSetCompare) && (c.cnt <= c.act.partBResetCompare);
      end
      if (q.inCtrl[n][IN_OVL_BIT]) begin
        onB = onB && !onA;
      end
      d.chan[n].waveA = run && onA && c.actEn[0];
      d.chan[n].waveB = run && onB && c.actEn[1];
      d.chan[n].outA = ~(d.chan[n].waveA ^ c.actPol[0]);
      d.chan[n].outB = ~(d.chan[n].waveB ^ c.actPol[1]);

      // Events and module outputs; a set beats a clear in the same cycle
      if (endEv) d.chan[n].endFlag = 1'b1;
      if (run && inEdge && faultMode) d.chan[n].faultFlag = 1'b1;
      d.chan[n].irq = (d.chan[n].endFlag && q.inCtrl[n][IN_ENDIE_BIT])
                      || (d.chan[n].faultFlag && q.inCtrl[n][IN_FLTIE_BIT]);
      d.chan[n].adcSync = run && tick && (c.cnt == c.act.partAResetCompare)
                          && (!center || c.phase == PH_UP);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset to idle, outputs at active-high inactive level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.outCfg <= OUTCFG_RST;
      q.outMode2 <= OUTMODE2_RST;
      q.inCtrl <= '{default: INCTRL_RST};
      for (int n = 0; n < NUM_MOD; n++) begin
        q.chan[n].phase <= PH_UP;
        q.chan[n].actPol <= 2'b11;
      end
    end else begin
      q <= d;
    end
  end

  // Ports straight from the state register
  always_comb begin
    regRdata = q.rdata;
    for (int n = 0; n < NUM_MOD; n++) begin
      moduleOutputA[n] = q.chan[n].outA;
      moduleOutputB[n] = q.chan[n].outB;
      moduleIrqRequest[n] = q.chan[n].irq;
      adcSyncOut[n] = q.chan[n].adcSync;
    end
  end

  // ----------------------------------------------------------------
  // Assertions on module 0
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_turnBottom;
    q.ctrl[CTRL_RUN_LSB] && q.ctrl[CTRL_CENTER_BIT] && tick && q.chan[0].phase == PH_DOWN && q.chan[0].cnt == '0;
  endsequence

  sequence s_faultHit;
    q.ctrl[CTRL_RUN_LSB] && q.inCtrl[0][IN_EN_BIT] && q.inCtrl[0][IN_FAULT_BIT]
      && (moduleFaultInput[0] == q.inCtrl[0][IN_LEVEL_BIT]) && (q.chan[0].inPrev != q.inCtrl[0][IN_LEVEL_BIT]);
  endsequence

  a_wrap_one_ramp:
    assert property (q.ctrl[CTRL_RUN_LSB] && !q.ctrl[CTRL_CENTER_BIT] && tick
                     && q.chan[0].cnt == q.chan[0].act.partBResetCompare |=> q.chan[0].cnt == '0)
      else $error("one-ramp counter did not restart after top");

  a_turn_bottom:
    assert property (s_turnBottom |=> q.chan[0].phase == PH_UP && q.chan[0].cnt == '0)
      else $error("centered counter did not turn at bottom");

  a_overlap_excl:
    assert property (q.inCtrl[0][IN_OVL_BIT] |=> !(q.chan[0].waveA && q.chan[0].waveB))
      else $error("both outputs active under overlap protection");

  a_stop_idle:
    assert property (!q.ctrl[CTRL_RUN_LSB] |=> !q.chan[0].waveA && !q.chan[0].waveB
                     && moduleOutputA[0] == !$past(q.chan[0].actPol[0]))
      else $error("stopped module drove an active output");

  a_lock_hold:
    assert property ($changed(q.chan[0].act) |-> $past(!q.ctrl[CTRL_LOCK_BIT]))
      else $error("compare values moved while locked");

  a_end_flag:
    assert property (q.ctrl[CTRL_RUN_LSB] && !q.ctrl[CTRL_CENTER_BIT] && tick
                     && q.chan[0].cnt == q.chan[0].act.partBResetCompare |=> q.chan[0].endFlag)
      else $error("end-of-cycle flag not raised on top match");

  a_fault_halt:
    assert property (s_faultHit |=> !q.ctrl[CTRL_RUN_LSB] && q.chan[0].faultFlag ##1 !q.chan[0].waveA)
      else $error("fault did not halt the module");

  a_wide_write:
    assert property (regBus.wr && regBus.addr == cmpAddr(0, OFF_A_SET)
                     |=> q.chan[0].pend.partASetCompare == {$past(q.temp[3:0]), $past(regBus.wdata)})
      else $error("low byte write did not merge the temp byte");

  a_one_ramp_a:
    assert property (q.ctrl[CTRL_RUN_LSB] && !q.ctrl[CTRL_CENTER_BIT]
                     && q.chan[0].cnt <= q.chan[0].act.partASetCompare |=> !q.chan[0].waveA)
      else $error("output A active inside its dead time");

endmodule // tpsc_top

`default_nettype wire

// >>> rtl/tpsc_pkg.sv
// Package of the three-module power stage PWM controller.
// Assumes one 100 MHz system clock and a byte-wide register port with one-cycle read latency.
package tpsc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_MOD = 3;
  localparam int CW = 12;
  localparam int AW = 6;
  localparam int DW = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] REG_CTRL = 6'h00;
  localparam logic [AW-1:0] REG_OUTCFG = 6'h01;
  localparam logic [AW-1:0] REG_OUTMODE2 = 6'h02;
  localparam logic [AW-1:0] REG_STATUS = 6'h03;
  localparam logic [AW-1:0] REG_TEMPHI = 6'h04;
  localparam logic [AW-1:0] REG_INCTRL_BASE = 6'h08;
  localparam logic [AW-1:0] REG_CMP_BASE = 6'h10;
  localparam logic [AW-1:0] CMP_STRIDE = 6'h08;
  localparam logic [AW-1:0] OFF_A_SET = 6'h00;
  localparam logic [AW-1:0] OFF_A_RESET = 6'h02;
  localparam logic [AW-1:0] OFF_B_SET = 6'h04;
  localparam logic [AW-1:0] REG_B_RESET = 6'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_LSB = 0;
  localparam int CTRL_CENTER_BIT = 3;
  localparam int CTRL_LOCK_BIT = 4;
  localparam int CTRL_CLKSEL_BIT = 5;
  localparam int CTRL_DIV_LSB = 6;
  localparam int IN_EN_BIT = 0;
  localparam int IN_FAULT_BIT = 1;
  localparam int IN_LEVEL_BIT = 2;
  localparam int IN_OVL_BIT = 3;
  localparam int IN_ENDIE_BIT = 4;
  localparam int IN_FLTIE_BIT = 5;
  localparam int STAT_FAULT_LSB = 3;

  // ----------------------------------------------------------------
  // Reset values and divider masks
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] CTRL_RST = 8'h00;
  localparam logic [DW-1:0] OUTCFG_RST = 8'h00;
  localparam logic [DW-1:0] OUTMODE2_RST = 8'h3F;
  localparam logic [DW-1:0] INCTRL_RST = 8'h00;
  localparam logic [DW-1:0] PRESC_STEP = 8'h01;
  localparam logic [DW-1:0] DIV_MASK [4] = '{8'h00, 8'h03, 8'h1F, 8'hFF};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_UP = 2'b01,
    PH_DOWN = 2'b10
  } tpsc_phase_t;

  typedef struct packed {
    logic [CW-1:0] partASetCompare;
    logic [CW-1:0] partAResetCompare;
    logic [CW-1:0] partBSetCompare;
    logic [CW-1:0] partBResetCompare;
  } tpsc_cmp_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } tpsc_bus_t;

  typedef struct packed {
    logic [CW-1:0] cnt;
    tpsc_phase_t phase;
    tpsc_cmp_t pend;
    tpsc_cmp_t act;
    logic [1:0] actEn;
    logic [1:0] actPol;
    logic inPrev;
    logic waveA;
    logic waveB;
    logic endFlag;
    logic faultFlag;
    logic irq;
    logic adcSync;
    logic outA;
    logic outB;
  } tpsc_chan_t;

  typedef struct packed {
    logic [DW-1:0] ctrl;
    logic [DW-1:0] outCfg;
    logic [DW-1:0] outMode2;
    logic [DW-1:0] temp;
    logic [NUM_MOD-1:0][DW-1:0] inCtrl;
    logic [CW-1:0] pendRb;
    logic [DW-1:0] presc;
    logic pllPrev;
    logic [DW-1:0] rdata;
    tpsc_chan_t [NUM_MOD-1:0] chan;
  } tpsc_state_t;

  // Byte address of one compare register of one module
  function automatic logic [AW-1:0] cmpAddr(input int n, input logic [AW-1:0] off);
    cmpAddr = AW'(REG_CMP_BASE + AW'(n) * CMP_STRIDE + off);
  endfunction

endpackage

// >>> sim/tpsc_bridge_model.sv
// Behavioural model of the external three-phase half-bridge gate stage.
// Assumes gate levels come straight from the controller pins; active level per gate given by mask.
`timescale 1ns/10ps
`default_nettype none
module tpsc_bridge_model (
  input wire logic [tpsc_pkg::NUM_MOD-1:0] gateA,
  input wire logic [tpsc_pkg::NUM_MOD-1:0] gateB,
  input wire logic [2*tpsc_pkg::NUM_MOD-1:0] actHigh,
  output logic [tpsc_pkg::NUM_MOD-1:0] legA,
  output logic [tpsc_pkg::NUM_MOD-1:0] legB,
  output logic [tpsc_pkg::NUM_MOD-1:0] shoot
);
  import tpsc_pkg::*;

  // Decode each gate against its active level; both switches on is cross conduction
  always_comb begin
    for (int n = 0; n < NUM_MOD; n++) begin
      legA[n] = (gateA[n] === actHigh[2*n]);
      legB[n] = (gateB[n] === actHigh[2*n+1]);
      shoot[n] = legA[n] && legB[n];
    end
  end
endmodule // tpsc_bridge_model
`default_nettype wire

// >>> sim/tpsc_top_tb_top.sv
// Self-checking bench of the three-module PWM controller with a half-bridge model.
// Assumes tpsc_pkg register map and one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tpsc_top_tb_top;
  import tpsc_pkg::*;
  logic sys_clk, rst_n, pllClkIn;
  tpsc_bus_t regBus;
  logic [DW-1:0] regRdata, rdv;
  logic [2:0] fltIn, outA, outB, irq, adc, legA, legB, shoot;
  logic [5:0] polMask;
  int badCount, checked, cA, cB, cS, cY, cD;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  tpsc_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .regBus(regBus), .regRdata(regRdata),
    .pllClkIn(pllClkIn), .moduleFaultInput(fltIn), .moduleOutputA(outA), .moduleOutputB(outB),
    .moduleIrqRequest(irq), .adcSyncOut(adc));
  tpsc_bridge_model BRIDGE (.gateA(outA), .gateB(outB), .actHigh(polMask), .legA(legA),
    .legB(legB), .shoot(shoot));
  // ----------------------------------------------------------------
  // Clock, PLL clock at half rate, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) pllClkIn <= ~pllClkIn;
  initial begin
    #500000;
    badCount++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    regBus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge sys_clk);
    regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    regBus.rd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  // High byte into the shared temporary byte first, low byte loads all twelve bits
  task automatic wr16(input logic [AW-1:0] a, input logic [CW-1:0] v);
    wr(a + 6'h01, {4'h0, v[11:8]});
    wr(a, v[7:0]);
  endtask
  task automatic setCmp(input int n, input logic [CW-1:0] sa, ra, sb, rb);
    logic [AW-1:0] b;
    b = REG_CMP_BASE + 6'(8 * n);
    wr16(b + OFF_A_SET, sa);
    wr16(b + OFF_A_RESET, ra);
    wr16(b + OFF_B_SET, sb);
    wr16(REG_B_RESET, rb);
  endtask
  // Counts on-cycles, cross conduction and ADC pulses of module n, and B misalignment of modules 0 and 1
  task automatic measure(input int n, input int cyc);
    cA = 0; cB = 0; cS = 0; cY = 0; cD = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1;
      cA += int'(legA[n]); cB += int'(legB[n]); cS += int'(shoot[n]);
      cY += int'(adc[n]); cD += int'(outB[0] !== outB[1]);
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(REG_OUTMODE2); chk(16'(rdv), 16'(OUTMODE2_RST), "polarity reset");
    rd(REG_CTRL); chk(16'(rdv), 16'(CTRL_RST), "control reset");
    wr16(REG_CMP_BASE + 6'h08, 12'hA34);
    rd(REG_CMP_BASE + 6'h08); chk(16'(rdv), 16'h0034, "compare low");
    rd(REG_CMP_BASE + 6'h09); chk(16'(rdv), 16'h000A, "compare high");
    rd(6'h3F); chk(16'(rdv), 16'h0000, "unmapped read");
  endtask
  task automatic t_oneramp();
    wr(REG_OUTCFG, 8'h3F);
    wr(REG_INCTRL_BASE, 8'h10);
    setCmp(0, 12'd0, 12'd2, 12'd3, 12'd4);
    setCmp(1, 12'd0, 12'd2, 12'd3, 12'd4);
    wr(REG_CTRL, 8'h03);
    repeat (12) @(posedge sys_clk);
    measure(0, 20);
    chk(16'(cA), 16'd8, "one-ramp A on");
    chk(16'(cB), 16'd4, "one-ramp B on");
    chk(16'(cY), 16'd4, "adc pulses");
    chk(16'(cD), 16'd0, "B edges aligned");
    chk(16'(irq[0]), 16'd1, "end irq");
  endtask
  task automatic t_overlap();
    wr(REG_CTRL, 8'h00);
    setCmp(0, 12'd0, 12'd3, 12'd1, 12'd4);
    wr(REG_CTRL, 8'h01);
    repeat (12) @(posedge sys_clk);
    measure(0, 20); chk(16'(cS), 16'd8, "overlap allowed");
    wr(REG_INCTRL_BASE, 8'h18);
    repeat (12) @(posedge sys_clk);
    measure(0, 20); chk(16'(cS), 16'd0, "overlap blocked");
  endtask
  task automatic t_lock();
    wr(REG_CTRL, 8'h00);
    wr(REG_INCTRL_BASE, 8'h10);
    setCmp(0, 12'd0, 12'd2, 12'd3, 12'd4);
    wr(REG_CTRL, 8'h01);
    wr(REG_CTRL, 8'h11);
    wr16(REG_CMP_BASE + OFF_A_RESET, 12'h001);
    repeat (10) @(posedge sys_clk);
    measure(0, 20); chk(16'(cA), 16'd8, "locked values held");
    wr(REG_CTRL, 8'h01);
    repeat (10) @(posedge sys_clk);
    measure(0, 20); chk(16'(cA), 16'd4, "values moved at cycle end");
  endtask
  task automatic t_center();
    wr(REG_CTRL, 8'h00);
    setCmp(0, 12'd1, 12'd2, 12'd3, 12'd4);
    wr(REG_CTRL, 8'h09);
    repeat (22) @(posedge sys_clk);
    measure(0, 20);
    chk(16'(cA), 16'd4, "centered A on");
    chk(16'(cB), 16'd8, "centered B on");
    chk(16'(cY), 16'd2, "centered adc pulses");
  endtask
  task automatic t_clock();
    logic [DW-1:0] ctl [5] = '{8'h01, 8'h41, 8'h81, 8'hC1, 8'h21};
    int dv [5] = '{1, 4, 32, 256, 2};
    for (int i = 0; i < 5; i++) begin
      wr(REG_CTRL, 8'h00);
      setCmp(0, 12'd0, 12'd2, 12'd3, 12'd4);
      wr(REG_CTRL, ctl[i]);
      repeat (12 * dv[i]) @(posedge sys_clk);
      measure(0, 10 * dv[i]);
      chk(16'(cA), 16'(4 * dv[i]), "divided A on");
      chk(16'(cB), 16'(2 * dv[i]), "divided B on");
    end
  endtask
  task automatic t_fault();
    wr(REG_CTRL, 8'h01);
    wr(REG_INCTRL_BASE, 8'h27);
    repeat (5) @(posedge sys_clk);
    fltIn <= 3'b001;
    repeat (5) @(posedge sys_clk);
    rd(REG_CTRL); chk(16'(rdv), 16'h0000, "fault stops run");
    rd(REG_STATUS); chk(16'(rdv[STAT_FAULT_LSB]), 16'd1, "fault flag");
    chk(16'(irq[0]), 16'd1, "fault irq");
    chk(16'({outA[0], outB[0]}), 16'd0, "outputs inactive");
    fltIn <= 3'b000;
    polMask <= 6'h3E;
    wr(REG_OUTMODE2, 8'h3E);
    repeat (3) @(posedge sys_clk);
    #1 chk(16'(outA[0]), 16'd1, "active-low idle level");
  endtask
  // Retrigger pulses every third cycle keep the counter below top: no B, no end flag
  task automatic t_retrig();
    wr(REG_CTRL, 8'h00);
    wr(REG_STATUS, 8'h09);
    wr(REG_INCTRL_BASE, 8'h05);
    wr(REG_CTRL, 8'h01);
    cA = 0; cB = 0;
    for (int i = 0; i < 30; i++) begin
      @(posedge sys_clk);
      fltIn <= (i % 3 == 0) ? 3'b001 : 3'b000;
      #1;
      cA += int'(legA[0]);
      cB += int'(legB[0]);
    end
    chk(16'(cB), 16'd0, "retrigger keeps B off");
    chk(16'(cA != 0), 16'd1, "retrigger keeps A");
    rd(REG_STATUS); chk(16'({rdv[STAT_FAULT_LSB], rdv[0]}), 16'd0, "flags cleared");
    chk(16'(irq[0]), 16'd0, "irq quiet");
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 0; pllClkIn = 0; fltIn = 0; polMask = 6'h3F; regBus = '0;
    badCount = 0; checked = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_oneramp();
    t_overlap();
    t_lock();
    t_center();
    t_clock();
    t_fault();
    t_retrig();
    print_verdict();
  end
endmodule // tpsc_top_tb_top
`default_nettype wire
